// [guard_timer_pkg.sv]
// Shared constants and carrier types for the guard timer block
package guard_timer_pkg;

   // APB byte addresses of the register map
   localparam logic [11:0] ADDR_CONFIG = 12'h0034;
   localparam logic [11:0] ADDR_COMMAND = 12'h0038;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h003C;
   localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h0040;
   localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h0044;
   localparam logic [11:0] ADDR_MODE = 12'h0048;
   localparam logic [11:0] ADDR_STATE = 12'h004C;

   // Command codes accepted by guard_timer_command
   localparam logic [7:0] CODE_CLEAR = 8'h4E;
   localparam logic [7:0] CODE_DISABLE = 8'hB1;
   localparam logic [7:0] CODE_TRAP_COMMIT = 8'hD2;

   // Field layout of guard_timer_config (low six bits of the word)
   localparam int CFG_WIDTH = 6;
   localparam int CMD_WIDTH = 8;
   localparam logic [5:0] CFG_RESET = 6'h39;

   // Interrupt status, clear and enable bit positions
   localparam int IRQ_W = 2;
   localparam int IRQ_TIMEOUT_BIT = 0;
   localparam int IRQ_RESET_BIT = 1;

   // Mode register: divider source select position
   localparam int MODE_DIV_SRC_BIT = 0;

   // Binary counter stages after the prescaler
   localparam int STAGE_BITS = 2;
   localparam logic [1:0] STAGE_LAST = 2'h3;

   // Reset request length in high-frequency clock periods
   localparam int RESET_HOLD_FC = 24;

   // Default log2 of the longest detection period per clock source
   localparam int HF_LOG2_LONGEST = 25;
   localparam int LF_LOG2_LONGEST = 17;

   // Configuration fields, most significant first
   typedef struct packed {
      logic ram_trap_area_select;
      logic trap_action_select;
      logic guard_enable_bit;
      logic [1:0] detect_time_select;
      logic overflow_action_select;
   } guard_config_s;

endpackage

// [guard_prescaler.sv]
// Free-running internal divider feeding the binary counter stages
`timescale 1ns/100ps
module guard_prescaler #(
   parameter int WIDTH = 23
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Source tick and selected tap
   input wire logic src_tick,
   input wire logic [4:0] tap,
   // Carry out towards the binary counter
   output logic stage_tick
);

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic tick;
   } pre_state_s;

   pre_state_s q;
   pre_state_s d;
   logic [WIDTH-1:0] mask;

   // Mask of the low tap bits; carry when they are all ones
   always_comb begin
      mask = {WIDTH{1'b1}} >> (WIDTH - int'(tap));
      d = q;
      d.tick = 1'b0;
      if (src_tick) begin
         d.cnt = q.cnt + 1'b1;
         d.tick = ((q.cnt & mask) == mask);
      end
   end

   // Never cleared by software, only by the bus reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign stage_tick = q.tick;

endmodule

// [guard_reset_stretch.sv]
// Stretches an overflow into a reset request of bounded length
`timescale 1ns/100ps
module guard_reset_stretch #(
   parameter int HOLD = guard_timer_pkg::RESET_HOLD_FC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Start pulse and high-frequency period tick
   input wire logic start,
   input wire logic hf_tick,
   // Reset request level
   output logic req
);

   localparam int CW = $clog2(HOLD + 1);
   localparam logic [CW-1:0] LAST = CW'(HOLD - 1);

   typedef struct packed {
      logic req;
      logic [CW-1:0] cnt;
   } stretch_state_s;

   stretch_state_s q;
   stretch_state_s d;

   // Count high-frequency periods while the request stands
   always_comb begin
      d = q;
      if (start && !q.req) begin
         d.req = 1'b1;
         d.cnt = '0;
      end else if (q.req && hf_tick) begin
         if (q.cnt == LAST) begin
            d.req = 1'b0;
         end else begin
            d.cnt = q.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign req = q.req;

endmodule

// [guard_timer.sv]
// Watchdog guard timer with APB register access
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps

module guard_timer #(
   parameter int HF_LOG2_LONGEST = guard_timer_pkg::HF_LOG2_LONGEST,
   parameter int LF_LOG2_LONGEST = guard_timer_pkg::LF_LOG2_LONGEST,
   parameter int RESET_HOLD = guard_timer_pkg::RESET_HOLD_FC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock source ticks, one pclk cycle per source period
   input wire logic hf_tick,
   input wire logic lf_tick,
   // Operating mode from the power manager
   input wire logic slow_mode,
   input wire logic power_hold,
   // Overflow outcomes
   output logic guard_timeout_irq,
   output logic guard_reset_req,
   // Maskable summary interrupt
   output logic irq
);

   localparam int PRE_WIDTH = HF_LOG2_LONGEST - guard_timer_pkg::STAGE_BITS;
   localparam logic [4:0] HF_TAP_MAX = 5'(HF_LOG2_LONGEST - guard_timer_pkg::STAGE_BITS);
   localparam logic [4:0] LF_TAP_MAX = 5'(LF_LOG2_LONGEST - guard_timer_pkg::STAGE_BITS);

   typedef struct packed {
      guard_timer_pkg::guard_config_s cfg;
      logic active;
      logic [guard_timer_pkg::STAGE_BITS-1:0] bin_cnt;
      logic trap_committed;
      logic div_src_sel;
      logic [guard_timer_pkg::IRQ_W-1:0] irq_status;
      logic [guard_timer_pkg::IRQ_W-1:0] irq_enable;
      logic irq;
      logic timeout_irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } top_state_s;

   top_state_s q;
   top_state_s d;

   logic use_low_freq;
   logic src_tick;
   logic [4:0] tap;
   logic stage_tick;
   logic ovf_reset;
   logic reset_req;

   // Source and tap: slow mode always runs from the low-frequency clock
   assign use_low_freq = slow_mode | q.div_src_sel;
   assign src_tick = (use_low_freq ? lf_tick : hf_tick) & ~power_hold;
   // Each code step divides the period by four
   assign tap = (use_low_freq ? LF_TAP_MAX : HF_TAP_MAX)
      - {2'b00, q.cfg.detect_time_select, 1'b0};

   guard_prescaler #(
      .WIDTH(PRE_WIDTH)
   ) u_prescaler (
      .pclk(pclk),
      .presetn(presetn),
      .src_tick(src_tick),
      .tap(tap),
      .stage_tick(stage_tick)
   );

   guard_reset_stretch #(
      .HOLD(RESET_HOLD)
   ) u_reset_stretch (
      .pclk(pclk),
      .presetn(presetn),
      .start(ovf_reset),
      .hf_tick(hf_tick),
      .req(reset_req)
   );

   // Next state: counter, overflow, bus writes, interrupts and read data
   always_comb begin
      logic access;
      logic wr;
      logic ovf;
      logic [guard_timer_pkg::IRQ_W-1:0] irq_set;
      logic [guard_timer_pkg::IRQ_W-1:0] irq_clr;
      guard_timer_pkg::guard_config_s wcfg;
      logic [7:0] wcmd;
      access = 1'b0;
      wr = 1'b0;
      ovf = 1'b0;
      irq_set = '0;
      irq_clr = '0;
      wcfg = guard_timer_pkg::guard_config_s'(pwdata[guard_timer_pkg::CFG_WIDTH-1:0]);
      wcmd = pwdata[guard_timer_pkg::CMD_WIDTH-1:0];
      d = q;
      d.timeout_irq = 1'b0;
      d.pready = 1'b0;
      ovf_reset = 1'b0;

      // Counting only while enabled and not held by a low-power mode
      if (stage_tick && q.active && !power_hold) begin
         d.bin_cnt = q.bin_cnt + 1'b1;
         ovf = (q.bin_cnt == guard_timer_pkg::STAGE_LAST);
      end

      // Overflow outcome follows the action select
      if (ovf) begin
         if (q.cfg.overflow_action_select) begin
            ovf_reset = 1'b1;
            irq_set[guard_timer_pkg::IRQ_RESET_BIT] = 1'b1;
         end else begin
            // Non-maskable: no master flag gates this pulse
            d.timeout_irq = 1'b1;
            irq_set[guard_timer_pkg::IRQ_TIMEOUT_BIT] = 1'b1;
         end
      end

      // Writes take effect at the access edge with pready high
      access = psel && penable && q.pready;
      wr = access && pwrite;
      if (wr && !q.pslverr) begin
         if (paddr == guard_timer_pkg::ADDR_CONFIG) begin
            d.cfg.ram_trap_area_select = wcfg.ram_trap_area_select;
            d.cfg.trap_action_select = wcfg.trap_action_select;
            d.cfg.guard_enable_bit = wcfg.guard_enable_bit;
            d.cfg.detect_time_select = wcfg.detect_time_select;
            // Once cleared to interrupt, a write of 1 cannot return it
            d.cfg.overflow_action_select = q.cfg.overflow_action_select
               & wcfg.overflow_action_select;
            if (wcfg.guard_enable_bit) begin
               d.active = 1'b1;
            end
         end else if (paddr == guard_timer_pkg::ADDR_COMMAND) begin
            if (wcmd == guard_timer_pkg::CODE_CLEAR) begin
               // Clear wins over a coincident count; prescaler untouched
               d.bin_cnt = '0;
            end else if (wcmd == guard_timer_pkg::CODE_DISABLE) begin
               if (!q.cfg.guard_enable_bit) begin
                  d.active = 1'b0;
               end
            end else if (wcmd == guard_timer_pkg::CODE_TRAP_COMMIT) begin
               d.trap_committed = q.cfg.ram_trap_area_select;
            end
         end else if (paddr == guard_timer_pkg::ADDR_IRQ_CLEAR) begin
            irq_clr = pwdata[guard_timer_pkg::IRQ_W-1:0];
         end else if (paddr == guard_timer_pkg::ADDR_IRQ_ENABLE) begin
            d.irq_enable = pwdata[guard_timer_pkg::IRQ_W-1:0];
         end else if (paddr == guard_timer_pkg::ADDR_MODE) begin
            d.div_src_sel = pwdata[guard_timer_pkg::MODE_DIV_SRC_BIT];
         end
      end

      // Disabled timer keeps its binary counter at zero
      if (!d.active) begin
         d.bin_cnt = '0;
      end

      // Sticky status: a new event beats a clear in the same cycle
      d.irq_status = (q.irq_status & ~irq_clr) | irq_set;
      d.irq = |(d.irq_status & d.irq_enable);

      // Setup phase: decode, prepare read data, answer next cycle
      if (psel && !penable) begin
         d.pready = 1'b1;
         d.pslverr = 1'b0;
         d.prdata = '0;
         if (paddr == guard_timer_pkg::ADDR_CONFIG) begin
            // Write-only: reads give zero, which software must not rely on
            d.prdata = '0;
         end else if (paddr == guard_timer_pkg::ADDR_COMMAND) begin
            d.prdata = '0;
         end else if (paddr == guard_timer_pkg::ADDR_IRQ_STATUS) begin
            d.prdata[guard_timer_pkg::IRQ_W-1:0] = q.irq_status;
         end else if (paddr == guard_timer_pkg::ADDR_IRQ_CLEAR) begin
            d.prdata = '0;
         end else if (paddr == guard_timer_pkg::ADDR_IRQ_ENABLE) begin
            d.prdata[guard_timer_pkg::IRQ_W-1:0] = q.irq_enable;
         end else if (paddr == guard_timer_pkg::ADDR_MODE) begin
            d.prdata[guard_timer_pkg::MODE_DIV_SRC_BIT] = q.div_src_sel;
         end else if (paddr == guard_timer_pkg::ADDR_STATE) begin
            d.prdata[11:0] = {q.trap_committed, reset_req, q.bin_cnt, q.active,
               1'b0, q.cfg};
         end else begin
            d.pslverr = 1'b1;
         end
      end else if (access) begin
         d.pslverr = 1'b0;
      end
   end

   // Single state register; reset values make the timer run at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.cfg <= guard_timer_pkg::guard_config_s'(guard_timer_pkg::CFG_RESET);
         q.active <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flip-flops
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign guard_timeout_irq = q.timeout_irq;
   assign guard_reset_req = reset_req;
   assign irq = q.irq;

endmodule

// [guard_timer_checker.sv]
// Concurrent checks on the guard timer ports
`timescale 1ns/100ps
module guard_timer_checker #(
   parameter int RESET_HOLD = 24
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Timer
   input wire logic hf_tick,
   input wire logic power_hold,
   input wire logic guard_timeout_irq,
   input wire logic guard_reset_req
);
   logic [7:0] held_q;
   logic unmapped;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Decode mirrors the register map; anything else must be refused
   assign unmapped = (paddr < 12'h0034) || (paddr > 12'h004C) || (paddr[1:0] != 2'h0);
   // High-frequency periods seen inside one reset request, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) held_q <= 8'h00;
      else if (!guard_reset_req) held_q <= 8'h00;
      else if (hf_tick && held_q != 8'hFF) held_q <= held_q + 8'h01;
   end
   chk_reset_bound: assert property (
      guard_reset_req |-> held_q <= RESET_HOLD) else $error("reset request too long");
   chk_reset_held: assert property (
      $rose(guard_reset_req) |=> guard_reset_req) else $error("reset request too short");
   chk_timeout_pulse: assert property (
      guard_timeout_irq |=> !guard_timeout_irq) else $error("timeout not a pulse");
   chk_one_outcome: assert property (
      guard_timeout_irq |-> !$rose(guard_reset_req)) else $error("both outcomes at once");
   chk_hold_frozen: assert property (
      power_hold [*4] |-> !guard_timeout_irq && !$rose(guard_reset_req))
      else $error("overflow while frozen");
   chk_ready_next: assert property (
      psel && !penable |=> pready) else $error("no ready in access cycle");
   chk_ready_pulse: assert property (
      pready |=> !pready) else $error("ready longer than one cycle");
   chk_unmapped_err: assert property (
      psel && !penable && unmapped |=> pslverr) else $error("unmapped access not refused");
   // Main scenarios
   cov_timeout: cover property (guard_timeout_irq);
   cov_reset: cover property ($rose(guard_reset_req));
   cov_refused: cover property (pready && pslverr);
endmodule

bind guard_timer guard_timer_checker #(.RESET_HOLD(RESET_HOLD)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .hf_tick(hf_tick), .power_hold(power_hold),
   .guard_timeout_irq(guard_timeout_irq), .guard_reset_req(guard_reset_req));

// [test_guard_timer.sv]
// Self-checking bench for the guard timer
`timescale 1ns/100ps
module test_guard_timer;
   localparam int HF = 10;
   localparam int LF = 8;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, err, irq, guard_timeout_irq, guard_reset_req;
   logic hf_tick = 1'b1, lf_tick = 1'b0, slow_mode = 1'b0, power_hold = 1'b0;
   int bad_count = 0, n_tests = 0, n;
   guard_timer #(.HF_LOG2_LONGEST(HF), .LF_LOG2_LONGEST(LF), .RESET_HOLD(3)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hf_tick(hf_tick), .lf_tick(lf_tick), .slow_mode(slow_mode), .power_hold(power_hold),
      .guard_timeout_irq(guard_timeout_irq), .guard_reset_req(guard_reset_req), .irq(irq));
   // 20 MHz clock
   initial begin
      forever #25 pclk = ~pclk;
   end
   // Both sources tick every second cycle, out of phase, so stretch counts differ from pclk
   always @(posedge pclk) begin
      lf_tick <= ~lf_tick;
      hf_tick <= ~hf_tick;
   end
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; read data and error taken at the ready edge, then one idle cycle
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         bad_count++;
         tally_and_finish;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge: the next call never re-raises psel in the same step
      @(posedge pclk);
   endtask
   // Cycles until the next timeout pulse (sel 0) or reset request (sel 1)
   task automatic wait_for(input logic sel, output int cnt);
      cnt = 0;
      do begin
         @(posedge pclk);
         cnt++;
      end while ((sel ? guard_reset_req : guard_timeout_irq) !== 1'b1 && cnt < 3000);
      if (cnt >= 3000) begin
         bad_count++;
         tally_and_finish;
      end
   endtask
   // Clear code to the command register, from the main flow only
   task automatic kick;
      xfer(1'b1, guard_timer_pkg::ADDR_COMMAND, 32'(guard_timer_pkg::CODE_CLEAR));
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, guard_timer_pkg::ADDR_STATE, 32'h0000_0000);
      check(rd & 32'h0000_00FF, 32'h0000_00B9);
      xfer(1'b0, guard_timer_pkg::ADDR_CONFIG, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      xfer(1'b0, 12'h100, 32'h0000_0000);
      check(32'(err), 32'h0000_0001);
      // No software action: the default overflow asks for a reset
      wait_for(1'b1, n);
      // Clear just before the hold, as software must before stop
      kick();
      power_hold <= 1'b1;
      xfer(1'b0, guard_timer_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
      check(rd, 32'h0000_0002);
      xfer(1'b1, guard_timer_pkg::ADDR_IRQ_ENABLE, 32'h0000_0002);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h0000_0001);
      xfer(1'b1, guard_timer_pkg::ADDR_IRQ_CLEAR, 32'h0000_0003);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h0000_0000);
      // Action goes to interrupt once and cannot return; shortest period chosen
      xfer(1'b1, guard_timer_pkg::ADDR_CONFIG, 32'h0000_000E);
      xfer(1'b1, guard_timer_pkg::ADDR_CONFIG, 32'h0000_000F);
      xfer(1'b0, guard_timer_pkg::ADDR_STATE, 32'h0000_0000);
      check(rd & 32'h0000_003F, 32'h0000_000E);
      // Frozen counter keeps its value; running, it would step every 8 cycles
      xfer(1'b0, guard_timer_pkg::ADDR_STATE, 32'h0000_0000);
      n = int'(rd[9:8]);
      repeat (40) @(posedge pclk);
      xfer(1'b0, guard_timer_pkg::ADDR_STATE, 32'h0000_0000);
      check(32'(rd[9:8]), 32'(n));
      power_hold <= 1'b0;
      kick();
      // Period per code and source; the second interval is free of phase
      for (int s = 0; s < 3; s++) begin
         slow_mode <= (s == 2);
         xfer(1'b1, guard_timer_pkg::ADDR_MODE, 32'(s == 1));
         for (int c = 0; c < 4; c++) begin
            xfer(1'b1, guard_timer_pkg::ADDR_CONFIG, 32'(8 + 2 * c));
            wait_for(1'b0, n);
            wait_for(1'b0, n);
            check(32'(n), 32'(8 << ((s == 0 ? HF : LF) - 2 - 2 * c)));
            check(32'(guard_reset_req), 32'h0000_0000);
         end
      end
      // Timeout status set but masked, pulses seen regardless
      check(32'(irq), 32'h0000_0000);
      xfer(1'b1, guard_timer_pkg::ADDR_IRQ_ENABLE, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h0000_0001);
      // Clears every 3 cycles, well inside 3/4 of a 32-cycle period: no timeout
      xfer(1'b1, guard_timer_pkg::ADDR_CONFIG, 32'h0000_000C);
      kick();
      xfer(1'b1, guard_timer_pkg::ADDR_IRQ_CLEAR, 32'h0000_0001);
      repeat (8) kick();
      xfer(1'b0, guard_timer_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      check(32'(irq), 32'h0000_0000);
      kick();
      power_hold <= 1'b1;
      xfer(1'b1, guard_timer_pkg::ADDR_CONFIG, 32'h0000_002E);
      xfer(1'b0, guard_timer_pkg::ADDR_STATE, 32'h0000_0000);
      n = int'(rd);
      xfer(1'b1, guard_timer_pkg::ADDR_COMMAND, 32'h0000_0055);
      xfer(1'b0, guard_timer_pkg::ADDR_STATE, 32'h0000_0000);
      check(rd, 32'(n));
      xfer(1'b1, guard_timer_pkg::ADDR_COMMAND, 32'(guard_timer_pkg::CODE_TRAP_COMMIT));
      xfer(1'b1, guard_timer_pkg::ADDR_COMMAND, 32'(guard_timer_pkg::CODE_DISABLE));
      kick();
      xfer(1'b0, guard_timer_pkg::ADDR_STATE, 32'h0000_0000);
      check(rd & 32'h0000_0B80, 32'h0000_0880);
      // Keyed disable, then the counter stays cleared while running
      xfer(1'b1, guard_timer_pkg::ADDR_CONFIG, 32'h0000_0026);
      xfer(1'b1, guard_timer_pkg::ADDR_COMMAND, 32'(guard_timer_pkg::CODE_DISABLE));
      power_hold <= 1'b0;
      repeat (300) @(posedge pclk);
      xfer(1'b0, guard_timer_pkg::ADDR_STATE, 32'h0000_0000);
      check(rd & 32'h0000_0380, 32'h0000_0000);
      tally_and_finish;
   end
endmodule
